/* rtl/csdm_defines.vh */
// How it works
// - a correct key opens protected writes for the next four instruction cycles
// - interrupt requests are held off while the unlock window is open
// - key register reads bit 0 as window open, bits 7:1 as zero
// - only key 0xD8 unlocks the clock select, clock divider and watchdog group
// - stack pointer is 16 bits at 0x3E/0x3D, reset to top of ram
// - status bit 7 clear blocks every interrupt
// - taking an irq clears bit 7; return, on and off instructions set or clear it
// - status bit 6 is the bit store/load transfer bit
// - sign bit 4 always equals negative xor overflow
// - half carry 5, overflow 3, negative 2, zero 1, carry 0 follow alu results
// - program memory is 16-bit words under a 9-bit counter starting at word 0
// - data address 0x4000 reads program byte address zero
// - firmware writes into program memory are dropped
// - data addresses 0-63 are i/o, the next 32 are sram
// - lock bits and mapped program memory are read only
// - pre-decrement and post-increment adjust the pointer; indirect reaches everything
// - direct accesses only reach 0x0040 to 0x00BF
// - i/o instructions reach i/o addresses 0x00 to 0x3F
// - an sram access completes in two clock cycles
// - bit set, clear and test work only on i/o 0x00 to 0x1F
// - bit set and clear touch only the addressed bit
// - an irq needs its own enable and the global enable
`ifndef CSDM_DEFINES_VH
`define CSDM_DEFINES_VH
// i/o offsets
`define CSDM_SPL_ADDR 16'h003D
`define CSDM_SPH_ADDR 16'h003E
`define CSDM_CORE_STATUS_FLAGS_ADDR 16'h003F
`define CSDM_CCP_ADDR 16'h003C
`define CSDM_CLKMS_ADDR 16'h0037
`define CSDM_CLKPS_ADDR 16'h0036
`define CSDM_WDTCS_ADDR 16'h0031
// unlock
`define CSDM_CCP_KEY 8'hD8
`define CSDM_CCP_WINDOW 3'h4
// status bit positions
`define CSDM_SR_I 7
`define CSDM_SR_T 6
`define CSDM_SR_H 5
`define CSDM_SR_S 4
`define CSDM_SR_V 3
`define CSDM_SR_N 2
`define CSDM_SR_Z 1
`define CSDM_SR_C 0
`define CSDM_CORE_STATUS_FLAGS_RST 8'h00
// data map
`define CSDM_IO_LAST 16'h003F
`define CSDM_BIT_LAST 16'h001F
`define CSDM_SRAM_FIRST 16'h0040
`define CSDM_SRAM_LAST 16'h005F
`define CSDM_DIR_FIRST 16'h0040
`define CSDM_DIR_LAST 16'h00BF
`define CSDM_PM_BASE 16'h4000
`define CSDM_PM_BYTES 16'h0400
`define CSDM_PC_W 9
`define CSDM_LOCK_ADDR 16'h3F00
`define CSDM_TOP_OF_RAM 16'h005F
// access timing
`define CSDM_ACC_CYCLES 2'h2
// access modes
`define CSDM_M_IO 3'h0
`define CSDM_M_DIRECT 3'h1
`define CSDM_M_IND 3'h2
`define CSDM_M_PREDEC 3'h3
`define CSDM_M_POSTINC 3'h4
`define CSDM_M_BIT 3'h5
// bit operations
`define CSDM_B_SET 2'h0
`define CSDM_B_CLR 2'h1
`define CSDM_B_TEST 2'h2
`endif

/* rtl/csdm_sysregs.v */
`timescale 1ns/1ns
`include "csdm_defines.vh"
module csdm_sysregs #(
    parameter NIRQ = 8,
    parameter IW = 3,
    parameter [15:0] TOP_OF_RAM = `CSDM_TOP_OF_RAM,
    parameter [15:0] LOCK_ADDR = `CSDM_LOCK_ADDR
) (
    input wire clock_i,
    input wire rst_i,
    input wire acc_valid_i,
    input wire acc_write_i,
    input wire [2:0] acc_mode_i,
    input wire [15:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    input wire [1:0] bit_op_i,
    input wire [2:0] bit_sel_i,
    input wire [15:0] ptr_i,
    output wire acc_ready_o,
    output wire [7:0] acc_rdata_o,
    output wire acc_err_o,
    output wire bit_val_o,
    output wire [15:0] ptr_o,
    output wire ptr_upd_o,
    output wire io_wr_o,
    output wire [5:0] io_addr_o,
    output wire [7:0] io_wdata_o,
    output wire [7:0] io_wmask_o,
    input wire [7:0] io_rdata_i,
    output wire [`CSDM_PC_W-1:0] pm_addr_o,
    input wire [15:0] pm_rdata_i,
    input wire [7:0] lock_bits_i,
    input wire instr_done_i,
    input wire irq_taken_i,
    input wire return_from_irq_instr_i,
    input wire sei_i,
    input wire cli_i,
    input wire bst_i,
    input wire bst_val_i,
    input wire [4:0] alu_mask_i,
    input wire [4:0] alu_flags_i,
    input wire sp_step_i,
    input wire sp_up_i,
    input wire sp_two_i,
    input wire [NIRQ-1:0] irq_flag_i,
    input wire [NIRQ-1:0] irq_en_i,
    output wire irq_req_o,
    output wire [IW-1:0] irq_idx_o,
    output wire [15:0] sp_o,
    output wire [7:0] status_o,
    output wire unlock_o
);

localparam S_IDLE = 1'b0;
localparam S_BUSY = 1'b1;

reg state_q;
reg [1:0] wait_q;
reg [15:0] ea_q;
reg rd_q;
reg err_q;
reg test_q;
reg [2:0] bsel_q;
reg [15:0] ptr_new_q;
reg ptr_adj_q;
reg ready_q;
reg [7:0] rdata_q;
reg bit_val_q;
reg [15:0] ptr_q;
reg ptr_upd_q;
reg io_wr_q;
reg [5:0] io_addr_q;
reg [7:0] io_wdata_q;
reg [7:0] io_wmask_q;
reg [`CSDM_PC_W-1:0] pm_addr_q;
reg irq_req_q;
reg [IW-1:0] irq_idx_q;
reg [15:0] sp_q;
reg [15:0] sp_d;
reg [7:0] core_status_flags_q;
reg [7:0] core_status_flags_d;
reg [2:0] win_q;
reg [2:0] win_d;
reg [7:0] mem_q [0:31];

////////////////////////////////////////////////////////////////////////////
// address formation and range checks

wire [15:0] ptr_dec = ptr_i - 16'h0001;
wire [15:0] ptr_inc = ptr_i + 16'h0001;
reg [15:0] ea;
reg ok;

// each mode has its own reach; out-of-reach requests answer with an error
always @* begin
    ea = acc_addr_i;
    ok = 1'b1;
    case (acc_mode_i)
        `CSDM_M_IO: begin
            ea = {10'h000, acc_addr_i[5:0]};
            ok = (acc_addr_i <= `CSDM_IO_LAST);
        end
        `CSDM_M_DIRECT: begin
            ok = (acc_addr_i >= `CSDM_DIR_FIRST) && (acc_addr_i <= `CSDM_DIR_LAST);
        end
        `CSDM_M_IND: begin
            ea = ptr_i;
        end
        `CSDM_M_PREDEC: begin
            ea = ptr_dec;
        end
        `CSDM_M_POSTINC: begin
            ea = ptr_i;
        end
        `CSDM_M_BIT: begin
            ea = {11'h000, acc_addr_i[4:0]};
            ok = (acc_addr_i <= `CSDM_BIT_LAST);
        end
        default: begin
            ok = 1'b0;
        end
    endcase
end

// region decode of the effective address
wire is_io = (ea <= `CSDM_IO_LAST);
wire is_sram = (ea >= `CSDM_SRAM_FIRST) && (ea <= `CSDM_SRAM_LAST);
wire [15:0] pm_off = ea - `CSDM_PM_BASE;
wire is_pm = (ea >= `CSDM_PM_BASE) && (pm_off < `CSDM_PM_BYTES);
wire is_prot = (ea == `CSDM_CLKMS_ADDR) || (ea == `CSDM_CLKPS_ADDR)
    || (ea == `CSDM_WDTCS_ADDR);
wire is_bit = (acc_mode_i == `CSDM_M_BIT);
wire bit_wr = is_bit && (bit_op_i != `CSDM_B_TEST);

wire take = acc_valid_i && (state_q == S_IDLE) && !ready_q;
wire wr_take = take && ok && acc_write_i && !is_bit;
wire wr_spl = wr_take && (ea == `CSDM_SPL_ADDR);
wire wr_sph = wr_take && (ea == `CSDM_SPH_ADDR);
wire wr_core_status_flags = wr_take && (ea == `CSDM_CORE_STATUS_FLAGS_ADDR);
wire wr_ccp = wr_take && (ea == `CSDM_CCP_ADDR);
wire internal = (ea == `CSDM_SPL_ADDR) || (ea == `CSDM_SPH_ADDR)
    || (ea == `CSDM_CORE_STATUS_FLAGS_ADDR) || (ea == `CSDM_CCP_ADDR);
// protected targets only pass while the window is open
wire prot_ok = !is_prot || (win_q != 3'h0);
wire ext_wr = take && ok && is_io && !internal && prot_ok
    && ((acc_write_i && !is_bit) || bit_wr);

////////////////////////////////////////////////////////////////////////////
// next values of the unlock window, status and stack pointer

always @* begin
    win_d = win_q;
    if (wr_ccp && (acc_wdata_i == `CSDM_CCP_KEY)) begin
        win_d = `CSDM_CCP_WINDOW;
    end else if (instr_done_i && (win_q != 3'h0)) begin
        win_d = win_q - 3'h1;
    end
end

// later lines override earlier ones: hardware events beat software writes
always @* begin
    core_status_flags_d = core_status_flags_q;
    if (wr_core_status_flags) begin
        core_status_flags_d = acc_wdata_i;
    end
    if (alu_mask_i[4]) begin
        core_status_flags_d[`CSDM_SR_H] = alu_flags_i[4];
    end
    if (alu_mask_i[3]) begin
        core_status_flags_d[`CSDM_SR_V] = alu_flags_i[3];
    end
    if (alu_mask_i[2]) begin
        core_status_flags_d[`CSDM_SR_N] = alu_flags_i[2];
    end
    if (alu_mask_i[1]) begin
        core_status_flags_d[`CSDM_SR_Z] = alu_flags_i[1];
    end
    if (alu_mask_i[0]) begin
        core_status_flags_d[`CSDM_SR_C] = alu_flags_i[0];
    end
    if (bst_i) begin
        core_status_flags_d[`CSDM_SR_T] = bst_val_i;
    end
    if (sei_i || return_from_irq_instr_i) begin
        core_status_flags_d[`CSDM_SR_I] = 1'b1;
    end
    if (cli_i || irq_taken_i) begin
        core_status_flags_d[`CSDM_SR_I] = 1'b0;
    end
    // sign is derived, never stored from software
    core_status_flags_d[`CSDM_SR_S] = core_status_flags_d[`CSDM_SR_N] ^ core_status_flags_d[`CSDM_SR_V];
end

// software byte writes win over a push or pop in the same cycle
always @* begin
    sp_d = sp_q;
    if (wr_spl || wr_sph) begin
        if (wr_spl) begin
            sp_d[7:0] = acc_wdata_i;
        end
        if (wr_sph) begin
            sp_d[15:8] = acc_wdata_i;
        end
    end else if (sp_step_i) begin
        if (sp_up_i) begin
            sp_d = sp_q + (sp_two_i ? 16'h0002 : 16'h0001);
        end else begin
            sp_d = sp_q - (sp_two_i ? 16'h0002 : 16'h0001);
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// interrupt gating and priority

wire [NIRQ-1:0] live = irq_flag_i & irq_en_i;
reg [IW-1:0] pick;
integer k;

// lowest index wins, so scan downward
always @* begin
    pick = {IW{1'b0}};
    for (k = NIRQ - 1; k >= 0; k = k - 1) begin
        if (live[k]) begin
            pick = k[IW-1:0];
        end
    end
end

// next-state terms close the gap when the window opens or cli lands
wire irq_go = (|live) && core_status_flags_d[`CSDM_SR_I] && !cli_i
    && (win_d == 3'h0);

always @(posedge clock_i) begin
    if (rst_i) begin
        irq_req_q <= 1'b0;
        irq_idx_q <= {IW{1'b0}};
        win_q <= 3'h0;
        core_status_flags_q <= `CSDM_CORE_STATUS_FLAGS_RST;
        sp_q <= TOP_OF_RAM;
    end else begin
        irq_req_q <= irq_go;
        irq_idx_q <= pick;
        win_q <= win_d;
        core_status_flags_q <= core_status_flags_d;
        sp_q <= sp_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// sram storage; data content has no reset

always @(posedge clock_i) begin
    if (wr_take && is_sram) begin
        mem_q[ea[4:0]] <= acc_wdata_i;
    end
end

////////////////////////////////////////////////////////////////////////////
// access sequencer: take, wait, answer

reg [7:0] rd_mux;

// program memory, lock bits and unmapped space take no write at all
always @* begin
    rd_mux = 8'h00;
    if (ea_q == `CSDM_CCP_ADDR) begin
        rd_mux = {7'h00, (win_q != 3'h0)};
    end else if (ea_q == `CSDM_SPL_ADDR) begin
        rd_mux = sp_q[7:0];
    end else if (ea_q == `CSDM_SPH_ADDR) begin
        rd_mux = sp_q[15:8];
    end else if (ea_q == `CSDM_CORE_STATUS_FLAGS_ADDR) begin
        rd_mux = core_status_flags_q;
    end else if (ea_q <= `CSDM_IO_LAST) begin
        rd_mux = io_rdata_i;
    end else if ((ea_q >= `CSDM_SRAM_FIRST) && (ea_q <= `CSDM_SRAM_LAST)) begin
        rd_mux = mem_q[ea_q[4:0]];
    end else if ((ea_q >= `CSDM_PM_BASE) && (ea_q - `CSDM_PM_BASE < `CSDM_PM_BYTES)) begin
        rd_mux = ea_q[0] ? pm_rdata_i[15:8] : pm_rdata_i[7:0];
    end else if (ea_q == LOCK_ADDR) begin
        rd_mux = lock_bits_i;
    end
end

always @(posedge clock_i) begin
    if (rst_i) begin
        state_q <= S_IDLE;
        wait_q <= 2'h0;
        ea_q <= 16'h0000;
        rd_q <= 1'b0;
        err_q <= 1'b0;
        test_q <= 1'b0;
        bsel_q <= 3'h0;
        ptr_new_q <= 16'h0000;
        ptr_adj_q <= 1'b0;
        ready_q <= 1'b0;
        rdata_q <= 8'h00;
        bit_val_q <= 1'b0;
        ptr_q <= 16'h0000;
        ptr_upd_q <= 1'b0;
        io_wr_q <= 1'b0;
        io_addr_q <= 6'h00;
        io_wdata_q <= 8'h00;
        io_wmask_q <= 8'h00;
        pm_addr_q <= {`CSDM_PC_W{1'b0}};
    end else begin
        ready_q <= 1'b0;
        ptr_upd_q <= 1'b0;
        io_wr_q <= ext_wr;
        case (state_q)
            S_IDLE: begin
                if (take) begin
                    state_q <= S_BUSY;
                    wait_q <= `CSDM_ACC_CYCLES - 2'h1;
                    ea_q <= ea;
                    rd_q <= !acc_write_i && !is_bit;
                    err_q <= !ok;
                    test_q <= is_bit && (bit_op_i == `CSDM_B_TEST);
                    bsel_q <= bit_sel_i;
                    ptr_new_q <= (acc_mode_i == `CSDM_M_PREDEC) ? ptr_dec : ptr_inc;
                    ptr_adj_q <= (acc_mode_i == `CSDM_M_PREDEC)
                        || (acc_mode_i == `CSDM_M_POSTINC);
                    if (is_io) begin
                        io_addr_q <= ea[5:0];
                    end
                    if (is_pm) begin
                        pm_addr_q <= pm_off[`CSDM_PC_W:1];
                    end
                    // bit ops write a one-hot mask so flags beside it stay put
                    if (bit_wr) begin
                        io_wmask_q <= 8'h01 << bit_sel_i;
                        io_wdata_q <= (bit_op_i == `CSDM_B_SET) ? 8'hFF : 8'h00;
                    end else begin
                        io_wmask_q <= 8'hFF;
                        io_wdata_q <= acc_wdata_i;
                    end
                end
            end
            S_BUSY: begin
                if (wait_q <= 2'h1) begin
                    state_q <= S_IDLE;
                    ready_q <= 1'b1;
                    rdata_q <= (rd_q && !err_q) ? rd_mux : 8'h00;
                    bit_val_q <= test_q && !err_q && io_rdata_i[bsel_q];
                    if (ptr_adj_q) begin
                        ptr_q <= ptr_new_q;
                        ptr_upd_q <= 1'b1;
                    end
                end else begin
                    wait_q <= wait_q - 2'h1;
                end
            end
            default: begin
                state_q <= S_IDLE;
            end
        endcase
    end
end

// error flag follows the captured request into the answer cycle
reg err_out_q;

always @(posedge clock_i) begin
    if (rst_i) begin
        err_out_q <= 1'b0;
    end else begin
        err_out_q <= (state_q == S_BUSY) && (wait_q <= 2'h1) && err_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs, all straight from flops except unlock_o, decoded from win_q

assign acc_ready_o = ready_q;
assign acc_rdata_o = rdata_q;
assign acc_err_o = err_out_q;
assign bit_val_o = bit_val_q;
assign ptr_o = ptr_q;
assign ptr_upd_o = ptr_upd_q;
assign io_wr_o = io_wr_q;
assign io_addr_o = io_addr_q;
assign io_wdata_o = io_wdata_q;
assign io_wmask_o = io_wmask_q;
assign pm_addr_o = pm_addr_q;
assign irq_req_o = irq_req_q;
assign irq_idx_o = irq_idx_q;
assign sp_o = sp_q;
assign status_o = core_status_flags_q;
assign unlock_o = (win_q != 3'h0);

endmodule

/* testbench/csdm_props.sv */
`timescale 1ns/1ns
module csdm_props #(
    parameter [15:0] TOP_OF_RAM = 16'h005F
) (
    input wire clock_i,
    input wire rst_i,
    input wire acc_valid_i,
    input wire acc_ready_o,
    input wire acc_err_o,
    input wire ptr_upd_o,
    input wire io_wr_o,
    input wire [5:0] io_addr_o,
    input wire [7:0] io_wmask_o,
    input wire sei_i,
    input wire cli_i,
    input wire irq_taken_i,
    input wire bst_i,
    input wire bst_val_i,
    input wire irq_req_o,
    input wire [15:0] sp_o,
    input wire [7:0] status_o,
    input wire unlock_o
);
default clocking cb @(posedge clock_i);
endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////////////////////////
// a fresh request is taken at once; the answer follows one busy cycle later
sequence s_take;
    $rose(acc_valid_i);
endsequence
sequence s_answer;
    !acc_ready_o ##1 acc_ready_o;
endsequence
property p_two_cycle;
    s_take |=> s_answer;
endproperty
a_two_cycle: assert property (p_two_cycle) else $error("access answer late or early");
property p_err_ready;
    acc_err_o |-> acc_ready_o;
endproperty
a_err_ready: assert property (p_err_ready) else $error("error without answer");
property p_ptr_ready;
    ptr_upd_o |-> acc_ready_o;
endproperty
a_ptr_ready: assert property (p_ptr_ready) else $error("pointer update without answer");
////////////////////////////////////////////////////////////////////////////////
// status and interrupt gating
property p_sign;
    status_o[4] == (status_o[2] ^ status_o[3]);
endproperty
a_sign: assert property (p_sign) else $error("sign flag not n xor v");
property p_gie;
    !status_o[7] |-> !irq_req_o;
endproperty
a_gie: assert property (p_gie) else $error("irq with global enable clear");
property p_sei;
    sei_i && !cli_i && !irq_taken_i |=> status_o[7];
endproperty
a_sei: assert property (p_sei) else $error("global enable not set");
property p_taken;
    (irq_taken_i || cli_i) |=> !status_o[7] && !irq_req_o;
endproperty
a_taken: assert property (p_taken) else $error("global enable not cleared");
property p_bst;
    bst_i |=> status_o[6] == $past(bst_val_i);
endproperty
a_bst: assert property (p_bst) else $error("transfer bit not stored");
property p_window_irq;
    unlock_o |-> !irq_req_o;
endproperty
a_window_irq: assert property (p_window_irq) else $error("irq inside unlock window");
////////////////////////////////////////////////////////////////////////////////
// protected group passes only inside the window; bit ops touch one bit
property p_prot;
    io_wr_o && (io_addr_o == 6'h37 || io_addr_o == 6'h36 || io_addr_o == 6'h31)
        |-> $past(unlock_o);
endproperty
a_prot: assert property (p_prot) else $error("protected write while locked");
property p_mask;
    io_wr_o && io_wmask_o != 8'hFF |-> $onehot(io_wmask_o);
endproperty
a_mask: assert property (p_mask) else $error("bit op mask not one hot");
property p_rst;
    $fell(rst_i) |-> sp_o == TOP_OF_RAM && status_o == 8'h00 && !unlock_o;
endproperty
a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind csdm_sysregs csdm_props #(.TOP_OF_RAM(TOP_OF_RAM)) u_props (
    .clock_i(clock_i), .rst_i(rst_i), .acc_valid_i(acc_valid_i), .acc_ready_o(acc_ready_o),
    .acc_err_o(acc_err_o), .ptr_upd_o(ptr_upd_o), .io_wr_o(io_wr_o), .io_addr_o(io_addr_o),
    .io_wmask_o(io_wmask_o), .sei_i(sei_i), .cli_i(cli_i), .irq_taken_i(irq_taken_i),
    .bst_i(bst_i), .bst_val_i(bst_val_i), .irq_req_o(irq_req_o), .sp_o(sp_o),
    .status_o(status_o), .unlock_o(unlock_o));

/* testbench/csdm_cpu_model.sv */
`timescale 1ns/1ns
module csdm_cpu_model (
    input wire clock_i,
    input wire acc_ready_i,
    input wire [7:0] acc_rdata_i,
    input wire acc_err_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [2:0] acc_mode_o,
    output logic [15:0] acc_addr_o,
    output logic [7:0] acc_wdata_o,
    output logic [1:0] bit_op_o,
    output logic [2:0] bit_sel_o,
    output logic [15:0] ptr_o,
    output logic [5:0] ev_o
);
initial {acc_valid_o, acc_write_o, acc_mode_o, acc_addr_o, acc_wdata_o} = '0;
initial {bit_op_o, bit_sel_o, ptr_o, ev_o} = '0;
////////////////////////////////////////////////////////////////////////////////
// one load/store: held until the answer is seen, bounded at 8 edges
task access(input [2:0] m, input w, input [15:0] a, input [7:0] d, input [1:0] bo,
            input [2:0] bs, input [15:0] p, output [7:0] rd, output er, output integer lat);
    integer n;
    begin
        @(negedge clock_i);
        acc_valid_o = 1'b1;
        {acc_write_o, acc_mode_o, acc_addr_o, acc_wdata_o} = {w, m, a, d};
        {bit_op_o, bit_sel_o, ptr_o} = {bo, bs, p};
        n = 0;
        lat = 99;
        rd = 8'h00;
        er = 1'b1;
        while (n < 8 && lat == 99) begin
            @(posedge clock_i);
            #1;
            n = n + 1;
            if (acc_ready_i === 1'b1) begin
                lat = n;
                rd = acc_rdata_i;
                er = acc_err_i;
            end
        end
        @(negedge clock_i);
        acc_valid_o = 1'b0;
        // released lines must not look like a held request
        acc_addr_o = ~acc_addr_o;
        acc_wdata_o = ~acc_wdata_o;
    end
endtask
// one-cycle instruction event: done, taken, return, on, off, store
task pulse(input [5:0] e);
    begin
        @(negedge clock_i);
        ev_o = e;
        @(negedge clock_i);
        ev_o = 6'h00;
    end
endtask
endmodule

/* testbench/tb_csdm_sysregs.sv */
`timescale 1ns/1ns
module tb_csdm_sysregs;
logic clock_i = 0;
logic rst_i = 1;
wire acc_valid_i, acc_write_i, acc_ready_o, acc_err_o, bit_val_o, ptr_upd_o, io_wr_o;
wire instr_done_i, irq_taken_i, return_from_irq_instr_i, sei_i, cli_i, bst_i, irq_req_o, unlock_o;
wire [2:0] acc_mode_i, bit_sel_i, irq_idx_o;
wire [1:0] bit_op_i;
wire [15:0] acc_addr_i, ptr_i, ptr_o, sp_o;
wire [7:0] acc_wdata_i, acc_rdata_o, io_wdata_o, io_wmask_o, status_o;
wire [5:0] io_addr_o, ev;
wire [8:0] pm_addr_o;
logic bst_val_i, sp_step_i, sp_up_i, sp_two_i;
logic [4:0] alu_mask_i, alu_flags_i;
logic [7:0] irq_flag_i, irq_en_i, lock_bits_i, rd, last_mask;
logic [7:0] io_mem [0:63];
logic er;
integer lat, io_cnt = 0, err_total = 0, tests_run = 0;
wire [7:0] io_rdata_i = io_mem[io_addr_o];
wire [15:0] pm_rdata_i = {8'hC3 ^ pm_addr_o[7:0], 8'h3C ^ pm_addr_o[7:0]};
assign {instr_done_i, irq_taken_i, return_from_irq_instr_i, sei_i, cli_i, bst_i} = ev;
always #2 clock_i = ~clock_i;
csdm_sysregs uut (.*);
csdm_cpu_model cpu (.clock_i(clock_i), .acc_ready_i(acc_ready_o), .acc_rdata_i(acc_rdata_o),
    .acc_err_i(acc_err_o), .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i),
    .acc_mode_o(acc_mode_i), .acc_addr_o(acc_addr_i), .acc_wdata_o(acc_wdata_i),
    .bit_op_o(bit_op_i), .bit_sel_o(bit_sel_i), .ptr_o(ptr_i), .ev_o(ev));
// peripheral side: only masked bits change, as a real register would
always @(posedge clock_i) begin
    if (io_wr_o === 1'b1) begin
        io_mem[io_addr_o] <= (io_mem[io_addr_o] & ~io_wmask_o) | (io_wdata_o & io_wmask_o);
        io_cnt <= io_cnt + 1;
        last_mask <= io_wmask_o;
    end
end
////////////////////////////////////////////////////////////////////////////////
task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask
task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    end
endtask
// every access funnels here so a hang ends the run
task xfer(input [2:0] m, input w, input [15:0] a, input [7:0] d, input [1:0] bo,
          input [2:0] bs, input [15:0] p);
    begin
        cpu.access(m, w, a, d, bo, bs, p, rd, er, lat);
        if (lat == 99) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
endtask
task acc(input [2:0] m, input w, input [15:0] a, input [7:0] d);
    xfer(m, w, a, d, 2'h2, 3'h0, a);
endtask
task sample;
    begin
        @(posedge clock_i);
        #1;
    end
endtask
////////////////////////////////////////////////////////////////////////////////
task t_unlock;
    integer i;
    begin
        irq_flag_i = 8'h0C;
        irq_en_i = 8'h04;
        cpu.pulse(6'h04);
        acc(0, 1, 16'h003C, 8'h55);
        acc(0, 1, 16'h0037, 8'h01);
        chk("wrong key", unlock_o, 1'b0);
        chk("locked write", io_cnt, 0);
        acc(0, 1, 16'h003C, 8'hD8);
        chk("open", unlock_o, 1'b1);
        chk("irq held", irq_req_o, 1'b0);
        acc(0, 0, 16'h003C, 8'h00);
        chk("key read open", rd, 8'h01);
        for (i = 0; i < 3; i = i + 1)
            acc(0, 1, i == 0 ? 16'h0037 : i == 1 ? 16'h0036 : 16'h0031, 8'h00);
        chk("group writes", io_cnt, 3);
        repeat (3) cpu.pulse(6'h20);
        chk("still open", unlock_o, 1'b1);
        cpu.pulse(6'h20);
        chk("closed", unlock_o, 1'b0);
        acc(0, 0, 16'h003C, 8'h00);
        chk("key read closed", rd, 8'h00);
        chk("irq back", irq_req_o, 1'b1);
        chk("irq index", irq_idx_o, 3'h2);
        cpu.pulse(6'h10);
        chk("taken clears", status_o[7], 1'b0);
        chk("no irq", irq_req_o, 1'b0);
        irq_en_i = 8'h00;
        cpu.pulse(6'h04);
        sample;
        chk("enable off", irq_req_o, 1'b0);
        cpu.pulse(6'h02);
    end
endtask
task t_status;
    begin
        bst_val_i = 1;
        cpu.pulse(6'h01);
        chk("transfer bit", status_o[6], 1'b1);
        @(negedge clock_i);
        {alu_mask_i, alu_flags_i} = {5'h1F, 5'b10110};
        @(negedge clock_i);
        {alu_mask_i, alu_flags_i} = {5'h1F, 5'b01001};
        chk("flags a", status_o, 8'h76);
        @(negedge clock_i);
        alu_mask_i = 5'h00;
        chk("flags b", status_o, 8'h59);
        cpu.pulse(6'h08);
        chk("return sets", status_o[7], 1'b1);
        cpu.pulse(6'h02);
        chk("off clears", status_o[7], 1'b0);
    end
endtask
task t_stack;
    begin
        acc(0, 1, 16'h003D, 8'h5A);
        acc(0, 1, 16'h003E, 8'h01);
        chk("sp", sp_o, 16'h015A);
        acc(0, 0, 16'h003E, 8'h00);
        chk("sp high", rd, 8'h01);
        @(negedge clock_i);
        {sp_step_i, sp_two_i} = 2'b11;
        @(negedge clock_i);
        sp_step_i = 0;
        chk("sp push two", sp_o, 16'h0158);
        {sp_step_i, sp_up_i, sp_two_i} = 3'b110;
        @(negedge clock_i);
        {sp_step_i, sp_up_i} = 2'b00;
        chk("sp pop one", sp_o, 16'h0159);
    end
endtask
task t_map;
    begin
        acc(1, 1, 16'h0045, 8'h9C);
        acc(1, 0, 16'h0045, 8'h00);
        chk("sram", rd, 8'h9C);
        chk("latency", lat, 2);
        acc(2, 0, 16'h4006, 8'h00);
        chk("pm low", rd, 8'h3F);
        chk("pm word", pm_addr_o, 9'h003);
        acc(2, 1, 16'h4007, 8'h00);
        acc(2, 0, 16'h4007, 8'h00);
        chk("pm high ro", rd, 8'hC0);
        acc(2, 1, 16'h3F00, 8'h00);
        acc(2, 0, 16'h3F00, 8'h00);
        chk("lock ro", rd, 8'hA6);
        lock_bits_i = 8'h5B;
        acc(2, 0, 16'h3F00, 8'h00);
        chk("lock live", rd, 8'h5B);
        xfer(3, 1, 16'h0000, 8'h77, 2'h0, 3'h0, 16'h0050);
        chk("predec", ptr_o, 16'h004F);
        xfer(4, 0, 16'h0000, 8'h00, 2'h0, 3'h0, 16'h004F);
        chk("postinc data", rd, 8'h77);
        chk("postinc", ptr_o, 16'h0050);
    end
endtask
task t_reach;
    logic [19:0] tab [0:6];
    integer i;
    begin
        // top three bits are the mode, bit 16 the expected error
        tab = '{20'h3_003F, 20'h3_00C0, 20'h2_00BF, 20'h1_0040, 20'h8_003F, 20'hB_0020,
                20'hA_001F};
        for (i = 0; i < 7; i = i + 1) begin
            acc(tab[i][19:17], 0, tab[i][15:0], 8'h00);
            chk("reach", er, tab[i][16]);
        end
        acc(0, 1, 16'h0005, 8'hA0);
        xfer(5, 0, 16'h0005, 8'h00, 2'h0, 3'h0, 16'h0000);
        chk("bit set", io_mem[5], 8'hA1);
        chk("bit mask", last_mask, 8'h01);
        xfer(5, 0, 16'h0005, 8'h00, 2'h1, 3'h5, 16'h0000);
        chk("bit clear", io_mem[5], 8'h81);
        xfer(5, 0, 16'h0005, 8'h00, 2'h2, 3'h7, 16'h0000);
        chk("bit test", bit_val_o, 1'b1);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    foreach (io_mem[i]) io_mem[i] = 8'h00;
    {bst_val_i, sp_step_i, sp_up_i, sp_two_i} = 4'h0;
    {alu_mask_i, alu_flags_i} = 10'h000;
    {irq_flag_i, irq_en_i} = 16'h0000;
    lock_bits_i = 8'hA6;
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 0;
    chk("sp reset", sp_o, 16'h005F);
    chk("status reset", status_o, 8'h00);
    t_unlock;
    t_status;
    t_stack;
    t_map;
    t_reach;
    tally_and_finish;
end
initial begin
    #200000;
    err_total = err_total + 1;
    tally_and_finish;
end
endmodule
